// ### hdl/pdm_consts.svh
`ifndef PDM_CONSTS_SVH
`define PDM_CONSTS_SVH
// Register offsets on the plain register port.
`define OFS_STANDBY_MAIN 4'h0
`define OFS_STOP_B 4'h1
`define OFS_STOP_C 4'h2
`define OFS_STOP_D 4'h3
`define OFS_WDOG_CTRL 4'h4
`define OFS_WDOG_COUNT 4'h5
`define OFS_STATUS 4'h6
// Field positions.
`define BIT_STANDBY_SELECT_BIT_SEL 7
`define BIT_PIN_REFLECT 3
`define BIT_TIMER_GATE 4
`define BIT_SP2_GATE 2
`define BIT_SP1_GATE 1
`define BIT_SP0_GATE 0
`define BIT_HOST_GATE 4
`define BIT_RED_GATE 0
`define BIT_WD_ENABLE 7
`define BIT_DEBUG_GATE 7
`define BIT_BRK_GATE 6
`define BIT_CACHE_GATE 2
`define BIT_UMEM_GATE 1
// Watchdog clock divide select field.
`define WD_DIV_HI 2
`define WD_DIV_LO 0
// Zero fill above the status fields.
`define STATUS_PAD 5'h00
// Writable masks; reserved bits read as zero.
`define MASK_MAIN 8'h88
`define MASK_B 8'hc6
`define MASK_C 8'h17
`define MASK_D 8'h11
`define MASK_WD_CTRL 8'h87
// Reset values.
`define RST_REG 8'h00
// Watchdog counter value that starts a forced standby.
`define WD_TRIP 8'h80
// IRQ detect selection meaning low-level detection.
`define IRQ_LOW_LEVEL 2'b00
`endif

// ### hdl/pdm_pkg.sv
package pdm_pkg;
	// Power mode of the chip.
	typedef enum logic [1:0] {
		run = 2'b00,
		sleep = 2'b01,
		settle = 2'b11,
		standby = 2'b10
	} power_state_e;
	// Gated peripheral clock enables.
	typedef struct packed {
		logic timer;
		logic serial2;
		logic serial1;
		logic serial0;
		logic host;
		logic redundancy;
		logic debug;
		logic brk;
		logic cache;
		logic umem;
	} clock_enables_s;
	// Wake sources from the interrupt side.
	typedef struct packed {
		logic nmi;
		logic debug_irq;
		logic irq;
		logic periph_irq;
		logic [3:0] irq_level;
		logic [3:0] periph_level;
		logic [1:0] irq_detect_sel;
	} wake_s;
endpackage : pdm_pkg

// ### hdl/pdm_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a level from outside the clock domain.
module pdm_sync
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic d,
	output logic q
);
	// First stage is read only by the second stage.
	logic meta;
	// Both stages hold while the clock enable is low.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta <= 1'b0;
			q <= 1'b0;
		end
		else if (ce)
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : pdm_sync

// ### hdl/pdm_wdog.sv
`timescale 1ns/1ps
`include "pdm_consts.svh"
// Settling counter used to time the return from standby.
module pdm_wdog
#(
	parameter int WIDTH = 8
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic run,
	input wire logic [2:0] divide_sel,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_value,
	output logic [WIDTH-1:0] count,
	output logic trip
);
	// Prescaler that divides the clock as the divide select asks.
	logic [7:0] prescale;
	// Tick when the prescaler reaches its selected power of two.
	logic tick;
	always_comb
	begin
		tick = (prescale & ((8'h01 << divide_sel) - 8'h01)) == 8'h00;
	end
	// Prescaler free-runs while counting, so settling time grows with the select.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prescale <= 8'h00;
		else if (ce)
			prescale <= run ? prescale + 8'h01 : 8'h00;
	end
	// Counter loads from software and counts up on each tick.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			count <= '0;
		else if (ce)
		begin
			if (load)
				count <= load_value;
			else if (run && tick)
				count <= count + WIDTH'(1);
		end
	end
	// The trip pulses on the tick that carries the counter from 7f up to its top bit.
	assign trip = run && tick && (count == WIDTH'(`WD_TRIP) - WIDTH'(1));
endmodule : pdm_wdog

// ### hdl/power_down_mode_control.sv
`timescale 1ns/1ps
`include "pdm_consts.svh"
// Behaviour
// - Bit 4 stop-C gates compare-match timer clock.
// - Stop-C bits 2..0 gate serial ports.
// - Stop-D bit 4 gates host port clock.
// - Stop-D bit 0 gates redundancy clock.
// - Reserved module-stop bits read as zero.
// - Halt with select clear enters sleep.
// - Accepted interrupts end sleep, start exception.
// - Masked IRQ or peripheral interrupt cannot wake sleep.
// - Power-on or debug reset ends sleep.
// - Halt with select set enters standby.
// - Standby entry initialises timer registers.
// - NMI or IRQ wakes standby after delay.
// - Select left set re-enters locked standby.
// - Low-level IRQ detect cannot release standby.
// - Masked IRQ resumes after halt, else exception.
// - Power-on reset ends standby; clock output runs.
// - Module-stop set cuts peripheral clock.
// - Module standby ends on clear or reset.
// - Standby select is bit 7, resets zero.
module power_down_mode_control
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic halt_exec,
	input wire pdm_pkg::wake_s wake,
	input wire logic irq_pin_match,
	input wire logic [3:0] mask_level,
	input wire logic debug_reset,
	output pdm_pkg::clock_enables_s clk_en,
	output logic cpu_run,
	output logic take_exception,
	output logic resume_after_halt,
	output logic timer_init,
	output logic clock_out_en,
	output logic locked_standby
);
	import pdm_pkg::*;

	// Software-visible control registers.
	logic [7:0] standby_control_main;
	logic [7:0] module_stop_control_b;
	logic [7:0] module_stop_control_c;
	logic [7:0] module_stop_control_d;
	logic [7:0] watchdog_control_status;
	// Power mode state and its next value.
	power_state_e state;
	power_state_e next_state;
	// Synchronised IRQ pin match, which comes from an outside pin.
	logic irq_match_s;
	// Watchdog counter state and trip event.
	logic [7:0] watchdog_counter;
	logic wd_trip;
	// Watchdog load strobe from the register port.
	logic wd_load;
	// Qualified wake conditions.
	logic sleep_wake;
	logic standby_wake;
	logic irq_standby_ok;
	// Standby select bit as a named view.
	logic standby_select_bit;
	// Watchdog run condition, kept apart so the instance reads one net.
	logic wd_run;
	// Set on the return from standby; keeps the counter going while select stays set.
	logic post_wake;

	// Mask a write so that reserved bits always hold zero.
	function automatic logic [7:0] masked(input logic [7:0] v, input logic [7:0] m);
		masked = v & m;
	endfunction : masked

	// An interrupt is accepted only above the mask level.
	function automatic logic accepted(input logic req, input logic [3:0] lvl,
		input logic [3:0] msk);
		accepted = req && (lvl > msk);
	endfunction : accepted

	assign standby_select_bit = standby_control_main[`BIT_STANDBY_SELECT_BIT_SEL];
	assign wd_load = wr && (addr == `OFS_WDOG_COUNT);

	// The IRQ pin level crosses into the clock domain before use.
	pdm_sync u_irq_sync
	(
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.d(irq_pin_match),
		.q(irq_match_s)
	);

	// The counter runs while settling, and in normal running while select is set and
	// either the enable bit is on or the chip has just come back from standby.
	// The second case arms the forced standby when the handler forgets select.
	always_comb
	begin
		wd_run = (state == settle)
			|| (state == run && standby_select_bit
			&& (watchdog_control_status[`BIT_WD_ENABLE] || post_wake));
	end

	// Watchdog counts only while settling or while standby select stays set.
	pdm_wdog #(.WIDTH(8)) u_wdog
	(
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.run(wd_run),
		.divide_sel(watchdog_control_status[`WD_DIV_HI:`WD_DIV_LO]),
		.load(wd_load),
		.load_value(wdata),
		.count(watchdog_counter),
		.trip(wd_trip)
	);

	// Standby main register; select resets to zero.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			standby_control_main <= `RST_REG;
		else if (ce && wr && addr == `OFS_STANDBY_MAIN)
			standby_control_main <= masked(wdata, `MASK_MAIN);
	end

	// Module-stop registers; cleared by power-on reset only.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			module_stop_control_b <= `RST_REG;
			module_stop_control_c <= `RST_REG;
			module_stop_control_d <= `RST_REG;
		end
		else if (ce && wr)
		begin
			// Writes of zero end module standby for that peripheral.
			case (addr)
				`OFS_STOP_B: module_stop_control_b <= masked(wdata, `MASK_B);
				`OFS_STOP_C: module_stop_control_c <= masked(wdata, `MASK_C);
				`OFS_STOP_D: module_stop_control_d <= masked(wdata, `MASK_D);
				default: ;
			endcase
		end
	end

	// Watchdog control; software must stop and zero it before standby.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			watchdog_control_status <= `RST_REG;
		else if (ce && wr && addr == `OFS_WDOG_CTRL)
			watchdog_control_status <= masked(wdata, `MASK_WD_CTRL);
	end

	// Wake qualification for sleep: NMI, debug, and unmasked interrupts.
	always_comb
	begin
		sleep_wake = wake.nmi || wake.debug_irq
			|| accepted(wake.irq, wake.irq_level, mask_level)
			|| accepted(wake.periph_irq, wake.periph_level, mask_level);
	end

	// Wake qualification for standby: NMI, or IRQ with edge detect matching.
	always_comb
	begin
		irq_standby_ok = wake.irq && irq_match_s
			&& (wake.irq_detect_sel != `IRQ_LOW_LEVEL);
		standby_wake = !locked_standby && (wake.nmi || irq_standby_ok);
	end

	// Next-state logic for the power mode machine.
	always_comb
	begin
		next_state = state;
		unique case (state)
			run:
			begin
				// Halt picks sleep or standby from the select bit.
				if (halt_exec)
					next_state = standby_select_bit ? standby : sleep;
				else if (standby_select_bit && wd_trip)
					next_state = standby;
			end
			sleep:
			begin
				// Debug reset or accepted interrupt leaves sleep.
				if (debug_reset || sleep_wake)
					next_state = run;
			end
			standby:
			begin
				// Clocks come back while the settling delay runs.
				if (standby_wake)
					next_state = settle;
			end
			settle:
			begin
				// Leave standby only when the programmed delay expires.
				if (wd_trip)
					next_state = run;
			end
		endcase
	end

	// Power mode register; power-on reset ends every mode.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state <= run;
		else if (ce)
			state <= next_state;
	end

	// Post-wake flag: set as settling ends, cleared once select is cleared or on a new halt.
	// A set in the same cycle as a clear wins, so a wake is never lost.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			post_wake <= 1'b0;
		else if (ce)
		begin
			if (state == settle && wd_trip)
				post_wake <= 1'b1;
			else if (!standby_select_bit || halt_exec)
				post_wake <= 1'b0;
		end
	end

	// Locked standby: a trip with select still set can only end by reset.
	// Nothing but the power-on reset clears it, as the wake paths are shut off.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			locked_standby <= 1'b0;
		else if (ce && state == run && standby_select_bit && wd_trip && !halt_exec)
			locked_standby <= 1'b1;
	end

	// Exception and resume outputs for the CPU, one cycle on wake.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			take_exception <= 1'b0;
			resume_after_halt <= 1'b0;
		end
		else if (ce)
		begin
			take_exception <= 1'b0;
			resume_after_halt <= 1'b0;
			if (state == sleep && !debug_reset && sleep_wake)
				take_exception <= 1'b1;
			else if (state == settle && wd_trip)
			begin
				// Masked IRQ without NMI resumes after the halt opcode.
				if (!wake.nmi && !accepted(wake.irq, wake.irq_level, mask_level))
					resume_after_halt <= 1'b1;
				else
					take_exception <= 1'b1;
			end
		end
	end

	// Timer registers are initialised on standby entry.
	// The pulse rises on the same edge as the mode change and lasts one cycle.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			timer_init <= 1'b0;
		else if (ce)
			timer_init <= (state != standby) && (next_state == standby);
	end

	// Clock enables: stop bits gate each peripheral, standby stops all.
	// They follow next_state so that gating switches on the very edge the mode does.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			clk_en <= '1;
			cpu_run <= 1'b1;
			clock_out_en <= 1'b1;
		end
		else if (ce)
		begin
			cpu_run <= (next_state == run);
			clock_out_en <= (next_state != standby);
			clk_en.timer <= !module_stop_control_c[`BIT_TIMER_GATE]
				&& next_state != standby;
			clk_en.serial2 <= !module_stop_control_c[`BIT_SP2_GATE]
				&& next_state != standby;
			clk_en.serial1 <= !module_stop_control_c[`BIT_SP1_GATE]
				&& next_state != standby;
			clk_en.serial0 <= !module_stop_control_c[`BIT_SP0_GATE]
				&& next_state != standby;
			clk_en.host <= !module_stop_control_d[`BIT_HOST_GATE]
				&& next_state != standby;
			clk_en.redundancy <= !module_stop_control_d[`BIT_RED_GATE]
				&& next_state != standby;
			// Stop register B gates debug, break, cache and local memory.
			clk_en.debug <= !module_stop_control_b[`BIT_DEBUG_GATE]
				&& next_state != standby;
			clk_en.brk <= !module_stop_control_b[`BIT_BRK_GATE]
				&& next_state != standby;
			clk_en.cache <= !module_stop_control_b[`BIT_CACHE_GATE]
				&& next_state != standby;
			clk_en.umem <= !module_stop_control_b[`BIT_UMEM_GATE]
				&& next_state != standby;
		end
	end

	// Read data one cycle after the read strobe; unmapped reads give zero.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata <= `RST_REG;
		else if (ce)
		begin
			rdata <= `RST_REG;
			if (rd)
			begin
				case (addr)
					`OFS_STANDBY_MAIN: rdata <= standby_control_main;
					`OFS_STOP_B: rdata <= module_stop_control_b;
					`OFS_STOP_C: rdata <= module_stop_control_c;
					`OFS_STOP_D: rdata <= module_stop_control_d;
					`OFS_WDOG_CTRL: rdata <= watchdog_control_status;
					`OFS_WDOG_COUNT: rdata <= watchdog_counter;
					`OFS_STATUS: rdata <= {`STATUS_PAD, locked_standby, state};
					default: rdata <= `RST_REG;
				endcase
			end
		end
	end
endmodule : power_down_mode_control

// ### dv/pdm_checker_sva.sv
`timescale 1ns/1ps
// Port-level checks on gating, power-mode entry and wake-up of the controller.
module pdm_checker_sva
import pdm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic halt_exec,
	input wire pdm_pkg::wake_s wake,
	input wire logic [3:0] mask_level,
	input wire logic debug_reset,
	input wire pdm_pkg::clock_enables_s clk_en,
	input wire logic cpu_run,
	input wire logic take_exception,
	input wire logic timer_init,
	input wire logic clock_out_en,
	input wire logic locked_standby
);
	logic [7:0] sc; // Shadow of the timer and serial gate register.
	logic [7:0] sd; // Shadow of the host and redundancy gate register.
	logic sm; // Shadow of the standby select bit.
	logic slp; // High while the controller sits in sleep.
	logic w1;
	logic w2;
	logic live;
	// Gates are only compared two quiet cycles after a write, since clk_en is registered.
	assign live = clock_out_en && (cpu_run || slp) && !w1 && !w2;
	// Shadow registers follow every accepted write.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sc <= 8'h00;
			sd <= 8'h00;
			sm <= 1'b0;
			slp <= 1'b0;
			w1 <= 1'b0;
			w2 <= 1'b0;
		end
		else
		begin
			w1 <= wr && ce;
			w2 <= w1;
			if (wr && ce && addr == 4'h2) sc <= wdata;
			if (wr && ce && addr == 4'h3) sd <= wdata;
			if (wr && ce && addr == 4'h0) sm <= wdata[7];
			if (halt_exec && ce && cpu_run && !sm) slp <= 1'b1;
			else if (cpu_run) slp <= 1'b0;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_TIMER_GATE: assert property (live |-> clk_en.timer == !sc[4])
		else $error("timer gate wrong");
	AST_SERIAL_GATE: assert property (live |->
		{clk_en.serial2, clk_en.serial1, clk_en.serial0} == ~sc[2:0])
		else $error("serial gates wrong");
	AST_HOST_RED_GATE: assert property (live |-> {clk_en.host, clk_en.redundancy} ==
		{!sd[4], !sd[0]}) else $error("host or redundancy gate wrong");
	AST_SLEEP_ENTRY: assert property (halt_exec && ce && cpu_run && !sm |=>
		!cpu_run && clock_out_en) else $error("sleep entry wrong");
	AST_STANDBY_ENTRY: assert property (halt_exec && ce && cpu_run && sm |=> !cpu_run &&
		!clock_out_en && timer_init && !clk_en.timer) else $error("standby entry wrong");
	AST_MASKED_NO_WAKE: assert property (slp && !cpu_run && !wake.nmi && !wake.debug_irq &&
		!wake.irq && wake.periph_irq && wake.periph_level <= mask_level && !debug_reset |=>
		!cpu_run) else $error("masked interrupt woke sleep");
	AST_SLEEP_WAKE: assert property (slp && !cpu_run && wake.periph_irq &&
		wake.periph_level > mask_level |-> ##[1:3] (cpu_run && take_exception))
		else $error("accepted interrupt did not end sleep");
	AST_DEBUG_RESET_WAKE: assert property (slp && !cpu_run && debug_reset |-> ##[1:3] cpu_run)
		else $error("debug reset did not end sleep");
	AST_LOW_LEVEL_HOLD: assert property (!clock_out_en && !locked_standby && !wake.nmi &&
		wake.irq_detect_sel == 2'b00 |=> !clock_out_en) else $error("low level left standby");
	AST_LOCK_HOLDS: assert property (locked_standby |=> locked_standby && !clock_out_en)
		else $error("locked standby left");
endmodule : pdm_checker_sva

bind power_down_mode_control pdm_checker_sva chk_u (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
	.wdata(wdata), .wr(wr), .halt_exec(halt_exec), .wake(wake), .mask_level(mask_level),
	.debug_reset(debug_reset), .clk_en(clk_en), .cpu_run(cpu_run),
	.take_exception(take_exception), .timer_init(timer_init), .clock_out_en(clock_out_en),
	.locked_standby(locked_standby));

// ### dv/pdm_cpu_model.sv
`timescale 1ns/1ps
// CPU and interrupt side: issues the halt opcode and presents wake sources.
module pdm_cpu_model
(
	input wire logic clk,
	output logic halt_exec,
	output pdm_pkg::wake_s wake,
	output logic irq_pin_match,
	output logic [3:0] mask_level,
	output logic debug_reset
);
	// Quiet sources from time zero.
	initial
	begin
		halt_exec = 1'b0;
		wake = '0;
		irq_pin_match = 1'b0;
		mask_level = 4'h0;
		debug_reset = 1'b0;
	end
	// One-cycle halt opcode.
	task halt();
		@(posedge clk);
		halt_exec <= 1'b1;
		@(posedge clk);
		halt_exec <= 1'b0;
	endtask : halt
	// Presents a new set of wake levels and mask, changed just after an edge.
	task raise(input pdm_pkg::wake_s w, input logic m, input logic [3:0] lv, input logic dr);
		@(posedge clk);
		wake <= w;
		irq_pin_match <= m;
		mask_level <= lv;
		debug_reset <= dr;
	endtask : raise
endmodule : pdm_cpu_model

// ### dv/power_down_mode_control_test.sv
`timescale 1ns/1ps
`include "pdm_consts.svh"
module power_down_mode_control_test;
	import pdm_pkg::*;
	logic clk, rst, ce, wr, rd, halt_exec, irq_pin_match, debug_reset;
	logic [3:0] addr, mask_level;
	logic [7:0] wdata, rdata, v;
	wake_s wake;
	clock_enables_s clk_en;
	logic cpu_run, take_exception, resume_after_halt, timer_init, clock_out_en, locked_standby;
	int mismatches, total_checks;
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	power_down_mode_control dut_u (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .halt_exec(halt_exec), .wake(wake),
		.irq_pin_match(irq_pin_match), .mask_level(mask_level), .debug_reset(debug_reset),
		.clk_en(clk_en), .cpu_run(cpu_run), .take_exception(take_exception),
		.resume_after_halt(resume_after_halt), .timer_init(timer_init),
		.clock_out_en(clock_out_en), .locked_standby(locked_standby));
	pdm_cpu_model model_u (.clk(clk), .halt_exec(halt_exec), .wake(wake),
		.irq_pin_match(irq_pin_match), .mask_level(mask_level), .debug_reset(debug_reset));
	task complete_run();
		if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks = total_checks + 1;
		if (g !== e)
		begin
			mismatches = mismatches + 1;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask : rd_reg
	// Bounded wait for the CPU to run again.
	task wait_run();
		for (int i = 0; i < 400 && cpu_run !== 1'b1; i++) @(negedge clk);
	endtask : wait_run
	// Reset values, reserved bits, unmapped read and gating of each clock.
	task t_regs();
		for (int a = 0; a < 7; a++)
		begin
			rd_reg(a[3:0]);
			chk("reset value", 8'h00, v);
		end
		// A write while the clock enable is low must leave the register alone.
		@(posedge clk);
		ce <= 1'b0;
		wr_reg(`OFS_STOP_C, 8'h10);
		ce <= 1'b1;
		rd_reg(`OFS_STOP_C);
		chk("frozen write", 8'h00, v);
		wr_reg(`OFS_STOP_C, 8'hff);
		wr_reg(`OFS_STOP_D, 8'hff);
		rd_reg(`OFS_STOP_C);
		chk("stop c", 8'h17, v);
		rd_reg(`OFS_STOP_D);
		chk("stop d", 8'h11, v);
		chk("gates off", 8'h00, {2'h0, clk_en.timer, clk_en.serial2, clk_en.serial1,
			clk_en.serial0, clk_en.host, clk_en.redundancy});
		wr_reg(`OFS_STOP_B, 8'hff);
		rd_reg(`OFS_STOP_B);
		chk("stop b", 8'hc6, v);
		chk("gates b", 8'h00, {4'h0, clk_en.debug, clk_en.brk, clk_en.cache, clk_en.umem});
		wr_reg(`OFS_STOP_B, 8'h00);
		rd_reg(4'hf);
		chk("unmapped", 8'h00, v);
		wr_reg(`OFS_STOP_C, 8'h00);
		wr_reg(`OFS_STOP_D, 8'h01);
		repeat (2) @(negedge clk);
		chk("gates on", 8'h3e, {2'h0, clk_en.timer, clk_en.serial2, clk_en.serial1,
			clk_en.serial0, clk_en.host, clk_en.redundancy});
	endtask : t_regs
	// Sleep: masked interrupt holds it, an accepted one and a debug reset end it.
	task t_sleep();
		model_u.halt();
		@(negedge clk);
		chk("sleep", 8'h01, {cpu_run, clock_out_en});
		model_u.raise(wake_s'(14'b0001_0000_0011_00), 1'b0, 4'h5, 1'b0);
		repeat (10) @(negedge clk);
		chk("masked", 8'h00, cpu_run);
		model_u.raise(wake_s'(14'b0001_0000_0110_00), 1'b0, 4'h5, 1'b0);
		wait_run();
		chk("wake", 8'h03, {cpu_run, take_exception});
		model_u.raise('0, 1'b0, 4'h5, 1'b0);
		model_u.halt();
		model_u.raise('0, 1'b0, 4'h5, 1'b1);
		wait_run();
		chk("debug reset", 8'h01, cpu_run);
		model_u.raise('0, 1'b0, 4'h5, 1'b0);
	endtask : t_sleep
	// Standby entry, low-level hold, NMI and masked IRQ exits, then locked standby.
	task t_standby();
		wr_reg(`OFS_WDOG_CTRL, 8'h00);
		wr_reg(`OFS_WDOG_COUNT, 8'h00);
		wr_reg(`OFS_STANDBY_MAIN, 8'h80);
		model_u.halt();
		@(negedge clk);
		chk("standby", 8'h01, {cpu_run, clock_out_en, clk_en.timer, timer_init});
		model_u.raise(wake_s'(14'b0010_1001_0000_00), 1'b1, 4'h0, 1'b0);
		repeat (20) @(negedge clk);
		chk("low level", 8'h00, clock_out_en);
		model_u.raise(wake_s'(14'b1000_0000_0000_00), 1'b0, 4'h0, 1'b0);
		wait_run();
		chk("nmi exit", 8'h03, {cpu_run, take_exception});
		model_u.raise('0, 1'b0, 4'h5, 1'b0);
		wr_reg(`OFS_WDOG_COUNT, 8'h00);
		model_u.halt();
		model_u.raise(wake_s'(14'b0010_0010_0000_01), 1'b1, 4'h5, 1'b0);
		wait_run();
		chk("resume", 8'h05, {cpu_run, take_exception, resume_after_halt});
		model_u.raise('0, 1'b0, 4'h5, 1'b0);
		wr_reg(`OFS_WDOG_COUNT, 8'h00);
		wr_reg(`OFS_WDOG_CTRL, 8'h00);
		for (int i = 0; i < 400 && locked_standby !== 1'b1; i++) @(negedge clk);
		chk("locked", 8'h01, {clock_out_en, locked_standby});
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("after reset", 8'h02, {clock_out_en, locked_standby});
		rd_reg(`OFS_STANDBY_MAIN);
		chk("select after reset", 8'h00, v);
	endtask : t_standby
	initial
	begin
		mismatches = 0;
		total_checks = 0;
		rst = 1'b1;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_sleep();
		t_standby();
		complete_run();
	end
	// Cuts a hang short well beyond the expected run length.
	initial
	begin
		repeat (5000) @(posedge clk);
		mismatches = mismatches + 1;
		complete_run();
	end
endmodule : power_down_mode_control_test
